// >>> common/tws_pkg.sv
// constants, field layout and carrier types of the two-wire status block
package tws_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_IE = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DBUF = 8'h0c;
    localparam logic [7:0] ADDR_SLA = 8'h10;
    localparam logic [7:0] ADDR_TOV = 8'h14;

    // ****************************************
    // status bit positions
    // ****************************************
    localparam int B_START = 0;
    localparam int B_TX = 1;
    localparam int B_RX = 2;
    localparam int B_STR = 3;
    localparam int B_TO = 4;
    localparam int B_AM = 5;
    localparam int B_AL = 6;
    localparam int B_NACK = 7;
    localparam int B_GC = 8;
    localparam int B_RO = 9;
    localparam int B_SCL = 10;
    localparam int B_SP = 11;
    localparam int B_BUSY = 14;
    localparam int B_BUS = 15;

    localparam logic [15:0] FLAG_MASK = 16'h0bff;
    localparam logic [15:0] SW_SET_MASK = 16'h0b33;
    localparam logic [15:0] SW_CLR_MASK = 16'h09ff;
    localparam logic [15:0] IE_MASK = 16'h0bff;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // ****************************************
    // control register bits
    // ****************************************
    localparam int C_EN = 0;
    localparam int C_MST = 1;
    localparam int C_GCEN = 2;
    localparam int C_STREN = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    localparam int DBUF_W = 10;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // events from the shift engine, same clock domain
    typedef struct packed {
        logic tx_done;
        logic rx_done;
        logic [7:0] rx_data;
        logic nack;
        logic arb_lost;
        logic start_fail;
        logic addr_valid;
        logic [6:0] addr;
        logic stretch_req;
        logic in_transfer;
        logic owns_bus;
    } tws_evt_t;
endpackage

// >>> src/tws_status.sv
// two-wire bus controller status flags with an axi4-lite register slave
//
// Contract
// - set transmit-complete flag after byte shifted out and ack bit received
// - set receive-ready flag when a data byte lands in the receive buffer
// - stretch enabled: set stretch flag, hold clock low until software clears
// - master mode: set timeout on start failure or clock low past limit
// - set address-match flag when received address equals own slave address
// - master losing arbitration sets arbitration-loss flag, clears master-mode bit
// - set nack flag when our transmitter receives a not-acknowledge
// - set general-call flag only when enabled and general call address received
// - set overrun flag when a second byte arrives before buffer read
// - buffer read clears overrun; writing zero to overrun does nothing
// - read-only bit shows present clock line level
// - set stop flag whenever a stop condition appears
// - status bits 13 and 12 always read zero
// - controller-busy set while in transfer or not owning the bus
// - bus-busy set on start or repeated start, cleared on stop
// - bus-busy forced zero on reset and while controller disabled
// - software writing one sets start, tx, timeout, match, gc, overrun, stop
// - receive, stretch, arbitration and nack flags settable only by hardware
// - event flags other than overrun stay set until software clears them by writing zero
// - clock level and bus-busy bits ignore software writes
// - set start flag on start or repeated start
// - data buffer writes accepted only while controller-busy is zero
module tws_status
    import tws_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [tws_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tws_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tws_pkg::tws_evt_t evt,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oen,
    output logic [tws_pkg::DBUF_W-1:0] tx_data,
    output logic tx_load,
    output logic [3:0] ctrl_out,
    output logic [6:0] own_slave_address_reg,
    output logic irq
);
    import tws_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    logic [15:0] flags;
    logic [15:0] next_flags;
    logic [15:0] hw_set;
    logic [15:0] sw_set;
    logic [15:0] sw_clr;
    logic [15:0] interrupt_enable;
    logic [15:0] timeout_value_reg;
    logic [15:0] to_cnt;
    logic [3:0] ctrl;
    logic [7:0] rx_buf;
    logic rx_unread;
    logic controller_busy;
    logic bus_busy;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic clock_line_level;
    logic sda_level;
    logic start_det;
    logic stop_det;
    logic to_expire;
    logic [ADDR_W-1:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic wr_go;
    logic [15:0] wmask;
    logic [15:0] wval;
    logic wr_status;
    logic rd_take;
    logic rd_dbuf;
    logic [31:0] rd_word;
    logic rd_hit;

    function automatic logic addr_hit(input logic valid, input logic [6:0] got, input logic [6:0] want);
        addr_hit = valid && (got == want);
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    // a level moves only when the second and third stages agree
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            clock_line_level <= 1'b1;
            sda_level <= 1'b1;
        end
        else if (ce)
        begin
            scl_sync <= {scl_sync[1:0], scl_i};
            sda_sync <= {sda_sync[1:0], sda_i};
            if (scl_sync[1] == scl_sync[2])
            begin
                clock_line_level <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2])
            begin
                sda_level <= sda_sync[2];
            end
        end
    end

    assign start_det = clock_line_level && sda_level && (sda_sync[1] == sda_sync[2]) && !sda_sync[2]
        && (scl_sync[1] == scl_sync[2]) && scl_sync[2];
    assign stop_det = clock_line_level && !sda_level && (sda_sync[1] == sda_sync[2]) && sda_sync[2]
        && (scl_sync[1] == scl_sync[2]) && scl_sync[2];

    // ****************************************
    // register bus decode
    // ****************************************
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wval = w_data[15:0] & wmask;
    assign wr_status = wr_go && (aw_addr == ADDR_STATUS);
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_dbuf = rd_take && (s_axi_araddr == ADDR_DBUF);

    always_comb
    begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            ADDR_STATUS: rd_word[15:0] = (flags & FLAG_MASK) | ({15'h0000, clock_line_level} << B_SCL)
                | ({15'h0000, controller_busy} << B_BUSY) | ({15'h0000, bus_busy} << B_BUS);
            ADDR_IE: rd_word[15:0] = interrupt_enable;
            ADDR_CTRL: rd_word[3:0] = ctrl;
            ADDR_DBUF: rd_word[7:0] = rx_buf;
            ADDR_SLA: rd_word[6:0] = own_slave_address_reg;
            ADDR_TOV: rd_word[15:0] = timeout_value_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    // ****************************************
    // write channel
    // ****************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    ADDR_STATUS, ADDR_IE, ADDR_CTRL, ADDR_DBUF, ADDR_SLA, ADDR_TOV: s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (rd_take)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            interrupt_enable <= STATUS_RESET;
            own_slave_address_reg <= 7'h00;
            timeout_value_reg <= 16'h0000;
        end
        else if (ce && wr_go)
        begin
            if (aw_addr == ADDR_IE)
            begin
                interrupt_enable <= (interrupt_enable & ~wmask) | (wval & IE_MASK);
            end
            if (aw_addr == ADDR_SLA && w_strb[0])
            begin
                own_slave_address_reg <= w_data[6:0];
            end
            if (aw_addr == ADDR_TOV)
            begin
                timeout_value_reg <= (timeout_value_reg & ~wmask) | wval;
            end
        end
    end

    // master bit: arbitration loss beats a software write
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl <= CTRL_RESET;
        end
        else if (ce)
        begin
            if (wr_go && aw_addr == ADDR_CTRL && w_strb[0])
            begin
                ctrl <= w_data[3:0];
            end
            if (ctrl[C_MST] && evt.arb_lost)
            begin
                ctrl[C_MST] <= 1'b0;
            end
        end
    end

    // ****************************************
    // data buffer
    // ****************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_data <= '0;
            tx_load <= 1'b0;
            rx_buf <= 8'h00;
            rx_unread <= 1'b0;
        end
        else if (ce)
        begin
            tx_load <= 1'b0;
            if (wr_go && aw_addr == ADDR_DBUF && !controller_busy)
            begin
                tx_data <= w_data[DBUF_W-1:0];
                tx_load <= 1'b1;
            end
            if (evt.rx_done)
            begin
                rx_buf <= evt.rx_data;
                rx_unread <= 1'b1;
            end
            else if (rd_dbuf)
            begin
                rx_unread <= 1'b0;
            end
        end
    end

    // ****************************************
    // timeout counter
    // ****************************************
    // counts mclk cycles of clock low; zero limit disables it
    assign to_expire = ctrl[C_MST] && !clock_line_level && (timeout_value_reg != 16'h0000)
        && (to_cnt == timeout_value_reg - 16'h0001);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            to_cnt <= 16'h0000;
        end
        else if (ce)
        begin
            if (!ctrl[C_MST] || clock_line_level)
            begin
                to_cnt <= 16'h0000;
            end
            else if (to_cnt != timeout_value_reg)
            begin
                to_cnt <= to_cnt + 16'h0001;
            end
        end
    end

    // ****************************************
    // event flags
    // ****************************************
    always_comb
    begin
        hw_set = 16'h0000;
        hw_set[B_START] = start_det;
        hw_set[B_TX] = evt.tx_done;
        hw_set[B_RX] = evt.rx_done;
        hw_set[B_STR] = ctrl[C_STREN] && evt.stretch_req;
        hw_set[B_TO] = ctrl[C_MST] && (evt.start_fail || to_expire);
        hw_set[B_AM] = addr_hit(evt.addr_valid, evt.addr, own_slave_address_reg);
        hw_set[B_AL] = ctrl[C_MST] && evt.arb_lost;
        hw_set[B_NACK] = evt.nack;
        hw_set[B_GC] = ctrl[C_GCEN] && addr_hit(evt.addr_valid, evt.addr, GC_ADDR);
        hw_set[B_RO] = evt.rx_done && rx_unread;
        hw_set[B_SP] = stop_det;
        sw_set = wr_status ? (wval & SW_SET_MASK) : 16'h0000;
        // zero clears, hardware-only bits excluded from set
        sw_clr = wr_status ? (~w_data[15:0] & wmask & SW_CLR_MASK) : 16'h0000;
        if (rd_dbuf)
        begin
            sw_clr[B_RO] = 1'b1;
        end
        // a set in the clearing cycle wins
        next_flags = ((flags & ~sw_clr) | sw_set | hw_set) & FLAG_MASK;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            flags <= STATUS_RESET;
        end
        else if (ce)
        begin
            flags <= next_flags;
        end
    end

    // ****************************************
    // live status bits and pin drive
    // ****************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            controller_busy <= 1'b0;
            bus_busy <= 1'b0;
        end
        else if (ce)
        begin
            controller_busy <= evt.in_transfer || !evt.owns_bus;
            if (!ctrl[C_EN])
            begin
                bus_busy <= 1'b0;
            end
            else if (start_det)
            begin
                bus_busy <= 1'b1;
            end
            else if (stop_det)
            begin
                bus_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_o <= 1'b0;
            scl_oen <= 1'b1;
            irq <= 1'b0;
            ctrl_out <= CTRL_RESET;
        end
        else if (ce)
        begin
            scl_o <= 1'b0;
            scl_oen <= !flags[B_STR];
            irq <= |(flags & interrupt_enable & FLAG_MASK);
            ctrl_out <= ctrl;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_sw_write_ones;
        ce && wr_status && (wval[B_RX] == 1'b1);
    endsequence

    property p_tx_set;
        ce && evt.tx_done |=> flags[B_TX];
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("tx flag not set");

    property p_rx_set;
        ce && evt.rx_done |=> flags[B_RX] && rx_unread;
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("rx flag not set");

    property p_stretch;
        ce && flags[B_STR] |=> !scl_oen;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not held");

    property p_arb;
        ce && ctrl[C_MST] && evt.arb_lost |=> !ctrl[C_MST] && flags[B_AL];
    endproperty
    a_arb: assert property (p_arb) else $error("arbitration loss mishandled");

    property p_gc_gate;
        ce && !ctrl[C_GCEN] && !flags[B_GC] && !wr_status |=> !flags[B_GC];
    endproperty
    a_gc_gate: assert property (p_gc_gate) else $error("general call set while disabled");

    property p_ro_clear;
        ce && rd_dbuf && !evt.rx_done |=> !flags[B_RO];
    endproperty
    a_ro_clear: assert property (p_ro_clear) else $error("overrun not cleared by read");

    property p_hw_only;
        s_sw_write_ones and (!flags[B_RX] && !evt.rx_done) |=> !flags[B_RX];
    endproperty
    a_hw_only: assert property (p_hw_only) else $error("software set receive flag");

    property p_bus_off;
        ce && !ctrl[C_EN] |=> !bus_busy;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus busy while disabled");

    property p_irq;
        ce |=> irq == $past(|(flags & interrupt_enable));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");

    property p_reserved;
        ce && rd_take && s_axi_araddr == ADDR_STATUS |=> s_axi_rdata[13:12] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bits nonzero");
endmodule

// >>> tb/tws_bus_model.sv
// far side model: shift engine events and the two bus lines
module tws_bus_model
    import tws_pkg::*;
(
    input wire logic mclk,
    output tws_pkg::tws_evt_t evt,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    import tws_pkg::*;

    logic own;

    // ****************************************
    // idle bus: pull-ups hold both lines high
    // ****************************************
    initial
    begin
        own = 1'b1;
        evt = '0;
        evt.owns_bus = 1'b1;
        scl = 1'b1;
        sda = 1'b1;
    end

    // one-cycle event, then a spare edge so back-to-back calls never collide
    task automatic pulse(input tws_evt_t e);
        e.owns_bus = own;
        evt <= e;
        @(posedge mclk);
        e = '0;
        e.owns_bus = own;
        evt <= e;
        @(posedge mclk);
    endtask

    task automatic set_own(input logic b);
        tws_evt_t z;
        own = b;
        z = '0;
        z.owns_bus = b;
        evt <= z;
    endtask

    // data line moves only while the clock line rests high: start or stop
    task automatic cond(input logic lvl);
        #62.5 sda = lvl;
        #62.5;
    endtask

    task automatic hold_clk(input logic lvl);
        scl <= lvl;
    endtask
endmodule

// >>> tb/two_wire_status_flags_bench.sv
// self-checking bench for the two-wire status block
module two_wire_status_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tws_pkg::*;

    logic mclk, rstn, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] strb;
    logic [1:0] bresp, rresp;
    logic scl, sda, scl_o, scl_oen, tx_load, irq;
    wire logic scl_w;
    logic [9:0] tx_data;
    logic [3:0] ctrl_out;
    logic [6:0] sla;
    tws_evt_t evt, e;
    int fail_count = 0;
    int n_checks = 0;
    int n_loads = 0;
    localparam logic [15:0] IDLE = 16'h0400;
    localparam logic [15:0] EXP [8] = '{16'h0404, 16'h0402, 16'h0480, 16'h0008,
                                        16'h0410, 16'h0420, 16'h0500, 16'h0440};

    // wired-and clock line: low enable means the block pulls it down
    assign scl_w = scl & (scl_oen | scl_o);

    tws_status tws_status_i (.mclk(mclk), .rstn(rstn), .ce(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .evt(evt), .scl_i(scl_w), .sda_i(sda), .scl_o(scl_o), .scl_oen(scl_oen), .tx_data(tx_data),
        .tx_load(tx_load), .ctrl_out(ctrl_out), .own_slave_address_reg(sla), .irq(irq));

    tws_bus_model tws_bus_model_i (.mclk(mclk), .evt(evt), .scl(scl), .sda(sda));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // load pulses are too short to catch inline
    always @(posedge mclk)
    begin
        if (tx_load)
            n_loads++;
    end

    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    // response ready rises only once the request handshakes are done and drops after, so only valid ends the wait
    task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {16'h0000, v};
        wvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (!bvalid && (!awvalid || awready) && (!wvalid || wready))
                bready <= 1'b1;
        end
        while (!bvalid);
        bready <= 1'b0;
        chk("bresp", er, bresp);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (!rvalid && (!arvalid || arready))
                rready <= 1'b1;
        end
        while (!rvalid);
        rready <= 1'b0;
        chk(nm, exp, rdata);
        chk("rresp", er, rresp);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        strb = 4'h3;
        bready = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rdc("status", ADDR_STATUS, IDLE, RESP_OKAY);
        wr(8'h18, 16'hffff, RESP_SLVERR);
        rdc("unmapped", 8'h18, 32'h0, RESP_SLVERR);
        wr(ADDR_STATUS, 16'hffff, RESP_OKAY);
        rdc("sw set", ADDR_STATUS, 32'h0f33, RESP_OKAY);
        wr(ADDR_STATUS, 16'h0000, RESP_OKAY);
        rdc("zero kept", ADDR_STATUS, 32'h0600, RESP_OKAY);
        rdc("dbuf", ADDR_DBUF, 32'h0, RESP_OKAY);
        rdc("read clears", ADDR_STATUS, IDLE, RESP_OKAY);
        wr(ADDR_SLA, 16'h002a, RESP_OKAY);
        wr(ADDR_CTRL, 16'h000f, RESP_OKAY);
        chk("slave addr", 32'h2a, sla);
        for (int i = 0; i < 8; i++)
        begin
            e = '0;
            e.addr = (i == 5) ? 7'h2a : 7'h00;
            case (i)
                0: e.rx_done = 1'b1;
                1: e.tx_done = 1'b1;
                2: e.nack = 1'b1;
                3: e.stretch_req = 1'b1;
                4: e.start_fail = 1'b1;
                5, 6: e.addr_valid = 1'b1;
                default: e.arb_lost = 1'b1;
            endcase
            tws_bus_model_i.pulse(e);
            repeat (8) @(posedge mclk);
            rdc("event flag", ADDR_STATUS, EXP[i], RESP_OKAY);
            chk("clock held", (i == 3) ? 1'b0 : 1'b1, scl_oen);
            chk("scl drive", 32'h0, scl_o);
            wr(ADDR_STATUS, 16'h0000, RESP_OKAY);
            repeat (8) @(posedge mclk);
            rdc("cleared", ADDR_STATUS, IDLE, RESP_OKAY);
        end
        rdc("master dropped", ADDR_CTRL, 32'h000d, RESP_OKAY);
        wr(ADDR_CTRL, 16'h0001, RESP_OKAY);
        e = '0;
        e.addr_valid = 1'b1;
        e.start_fail = 1'b1;
        tws_bus_model_i.pulse(e);
        rdc("no gc no timeout", ADDR_STATUS, IDLE, RESP_OKAY);
        e = '0;
        e.rx_done = 1'b1;
        e.rx_data = 8'h5a;
        rdc("dbuf", ADDR_DBUF, 32'h0, RESP_OKAY);
        tws_bus_model_i.pulse(e);
        rdc("one byte", ADDR_STATUS, 32'h0404, RESP_OKAY);
        e.rx_data = 8'ha5;
        tws_bus_model_i.pulse(e);
        rdc("overrun", ADDR_STATUS, 32'h0604, RESP_OKAY);
        rdc("last byte", ADDR_DBUF, 32'h00a5, RESP_OKAY);
        rdc("overrun gone", ADDR_STATUS, 32'h0404, RESP_OKAY);
        wr(ADDR_STATUS, 16'h0000, RESP_OKAY);
        // irq follows enable; lane 1 strobe off keeps upper byte
        strb <= 4'h1;
        wr(ADDR_IE, 16'h0bff, RESP_OKAY);
        strb <= 4'h3;
        rdc("lane0 only", ADDR_IE, 32'h00ff, RESP_OKAY);
        wr(ADDR_IE, 16'h0002, RESP_OKAY);
        wr(ADDR_STATUS, 16'h0002, RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk("irq on", 32'h1, irq);
        wr(ADDR_IE, 16'h0000, RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk("irq masked", 32'h0, irq);
        wr(ADDR_STATUS, 16'h0000, RESP_OKAY);
        // frozen clock enable drops a transfer event
        e = '0;
        e.tx_done = 1'b1;
        ce <= 1'b0;
        tws_bus_model_i.pulse(e);
        ce <= 1'b1;
        rdc("frozen", ADDR_STATUS, IDLE, RESP_OKAY);
        tws_bus_model_i.cond(1'b0);
        rdc("start", ADDR_STATUS, 32'h8401, RESP_OKAY);
        tws_bus_model_i.cond(1'b1);
        rdc("stop", ADDR_STATUS, 32'h0c01, RESP_OKAY);
        wr(ADDR_STATUS, 16'h0000, RESP_OKAY);
        tws_bus_model_i.cond(1'b0);
        wr(ADDR_CTRL, 16'h0000, RESP_OKAY);
        rdc("disabled", ADDR_STATUS, 32'h0401, RESP_OKAY);
        wr(ADDR_STATUS, 16'h0000, RESP_OKAY);
        tws_bus_model_i.cond(1'b1);
        rdc("stop only", ADDR_STATUS, 32'h0c00, RESP_OKAY);
        wr(ADDR_STATUS, 16'h0000, RESP_OKAY);
        wr(ADDR_TOV, 16'h0005, RESP_OKAY);
        wr(ADDR_CTRL, 16'h0003, RESP_OKAY);
        tws_bus_model_i.hold_clk(1'b0);
        repeat (20) @(posedge mclk);
        rdc("timeout", ADDR_STATUS, 32'h0010, RESP_OKAY);
        chk("ctrl out", 32'h3, ctrl_out);
        tws_bus_model_i.hold_clk(1'b1);
        repeat (8) @(posedge mclk);
        wr(ADDR_STATUS, 16'h0000, RESP_OKAY);
        wr(ADDR_DBUF, 16'h0155, RESP_OKAY);
        chk("tx data", 32'h155, tx_data);
        tws_bus_model_i.set_own(1'b0);
        repeat (2) @(posedge mclk);
        rdc("busy", ADDR_STATUS, 32'h4400, RESP_OKAY);
        wr(ADDR_DBUF, 16'h02aa, RESP_OKAY);
        chk("tx kept", 32'h155, tx_data);
        chk("tx loads", 32'h1, n_loads);
        wrap_up();
    end
endmodule
